// ===== hw/cps_config_port.sv
// Configuration load and readback port: pin side on configClock, core side on mclk.
// Assumes the host drives configClock; straps are static during a load.
`timescale 1ns/1ps

// Functional notes
// (R1) Busy after async write for 1..8 clocks
// (R2) Status read drives only top bit
// (R3) Host may write again once ready
// (R4) Async byte taken on select plus write
// (R5) Async byte shifted out on falling edges
// (R6) Sync mode first bit out 1.5 clocks later
// (R7) Serial input forwarded on next falling edge
// (R8) Parallel byte sampled on clock when selected
// (R9) Parallel mode has no daisy forwarding
// (R10) Request high two clocks aborts readback
// (R11) Readback bits shift out on clock
// (R12) Host waits after init before writing
// (R13) Daisy bytes go out MSB first
module cps_config_port (
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic              configClock,
   input  wire cps_pkg::cps_mode_t mode,
   input  wire logic              chipSelectA_n,
   input  wire logic              chipSelectB,
   input  wire logic              writeStrobe_n,
   input  wire logic              readStrobe_n,
   input  wire logic [7:0]        dataIn,
   output logic [7:0]             dataOut,
   output logic [7:0]             dataOe,
   output logic                   readyOut,
   input  wire logic              serialIn,
   output logic                   daisyOut,
   input  wire logic              readbackRequest_n,
   output logic                   readbackData,
   output cps_pkg::cps_byte_t     cfgWord,
   output logic                   cfgValid,
   input  wire logic              cfgReady,
   input  wire logic [7:0]        rbByte,
   output logic                   rbTake
);
   // ---------------- Link domain synchronisers ----------------
   logic [1:0]         rstMeta_q;
   logic               linkRst;
   cps_pkg::cps_mode_t modeMeta_q, mode_q;
   logic [11:0]        pinMeta_q, pinSync_q;
   logic               xAckMeta_q, xAckSync_q, rbAckMeta_q, rbAckSync_q, rbAckPrev_q;

   // Core side toggles read through two flops
   logic xAckTgl_q, rbAckTgl_q;

   always_ff @(posedge configClock) begin
      rstMeta_q   <= {rstMeta_q[0], reset};
      modeMeta_q  <= mode;
      mode_q      <= modeMeta_q;
      pinMeta_q   <= {chipSelectA_n, chipSelectB, writeStrobe_n, readStrobe_n, dataIn};
      pinSync_q   <= pinMeta_q;
      xAckMeta_q  <= xAckTgl_q;
      xAckSync_q  <= xAckMeta_q;
      rbAckMeta_q <= rbAckTgl_q;
      rbAckSync_q <= rbAckMeta_q;
      rbAckPrev_q <= rbAckSync_q;
   end
   assign linkRst = rstMeta_q[1];

   // ---------------- Link domain state ----------------
   cps_pkg::cps_ap_state_t apState_q, apState_d;
   logic               apWritePrev_q, apWritePrev_d;
   logic [7:0]         shift_q, shift_d;
   logic [3:0]         shiftCnt_q, shiftCnt_d;
   logic [7:0]         syncPipe_q, syncPipe_d;
   logic               syncPipeV_q, syncPipeV_d;
   logic               serialBit_q, serialBit_d;
   logic [7:0]         serAcc_q, serAcc_d;
   logic [2:0]         serCnt_q, serCnt_d;
   logic               readyOut_d, daisySrc;
   logic [7:0]         dataOut_d, dataOe_d;
   cps_pkg::cps_byte_t xData_q, xData_d;
   logic               xReqTgl_q, xReqTgl_d;
   logic               rbActive_q, rbActive_d;
   logic [1:0]         rbHigh_q, rbHigh_d;
   logic [7:0]         rbShift_q, rbShift_d;
   logic [3:0]         rbCnt_q, rbCnt_d;
   logic               rbFresh_q, rbFresh_d;
   logic               rbReqTgl_q, rbReqTgl_d;
   logic               readbackData_d;
   logic [7:0]         rbHold_q;

   logic               apWrite, apRead, rawSel, rawWrite;
   logic               apTake, syncTake, parTake, serTake;
   logic               fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
   cps_pkg::cps_byte_t fifoInData, fifoOutData;

   function automatic logic selected(input logic csA_n, input logic csB);
      selected = !csA_n && csB;
   endfunction

   always_comb begin
      apWrite  = selected(pinSync_q[11], pinSync_q[10]) && !pinSync_q[9];
      apRead   = selected(pinSync_q[11], pinSync_q[10]) && !pinSync_q[8];
      rawSel   = selected(chipSelectA_n, chipSelectB);
      rawWrite = rawSel && !writeStrobe_n;
      apTake   = (mode_q == cps_pkg::MODE_ASYNC) && (apState_q == cps_pkg::AP_IDLE)
                 && apWrite && !apWritePrev_q && fifoInReady;                         // R4
      syncTake = (mode_q == cps_pkg::MODE_SYNC) && rawWrite && fifoInReady;
      parTake  = (mode_q == cps_pkg::MODE_PARALLEL) && rawWrite && fifoInReady;      // R8
      serTake  = (mode_q == cps_pkg::MODE_SERIAL) && (serCnt_q == 3'h7) && fifoInReady;
   end

   // Async write handshake, daisy shifter and byte assembly
   always_comb begin
      apState_d     = apState_q;
      apWritePrev_d = apWrite;
      shift_d       = shift_q;
      shiftCnt_d    = shiftCnt_q;
      syncPipe_d    = dataIn;
      syncPipeV_d   = syncTake;
      serialBit_d   = serialIn;
      serAcc_d      = {serAcc_q[6:0], serialIn};
      serCnt_d      = serCnt_q;
      if (shiftCnt_q != 4'h0) begin
         shift_d    = {shift_q[6:0], 1'b0};                                        // R13
         shiftCnt_d = shiftCnt_q - 4'h1;
      end
      case (apState_q)
         cps_pkg::AP_IDLE: begin
            if (apTake) begin
               apState_d  = cps_pkg::AP_SHIFT;
               shift_d    = pinSync_q[7:0];                                        // R5
               shiftCnt_d = cps_pkg::SHIFT_CLOCKS;
            end
         end
         cps_pkg::AP_SHIFT: begin
            if (shiftCnt_q <= 4'h1) begin
               apState_d = cps_pkg::AP_WAIT;                                       // R1
            end
         end
         default: begin
            if (!apWrite) begin
               apState_d = cps_pkg::AP_IDLE;
            end
         end
      endcase
      // One stage before loading gives the extra clock of sync mode
      if (syncPipeV_q) begin
         shift_d    = syncPipe_q;                                                  // R6
         shiftCnt_d = cps_pkg::SHIFT_CLOCKS;
      end
      if (mode_q == cps_pkg::MODE_SERIAL) begin
         if (serCnt_q != 3'h7) begin
            serCnt_d = serCnt_q + 3'h1;
         end else if (serTake) begin
            serCnt_d = 3'h0;
         end
      end else begin
         serCnt_d = 3'h0;
      end
      // Busy covers the whole async shift-out, or a full buffer
      readyOut_d = (apState_d != cps_pkg::AP_SHIFT) && fifoInReady;                 // R1
      dataOe_d   = {apRead, 7'h00};                                                 // R2
      dataOut_d  = {readyOut_d, 7'h00};
   end

   always_comb begin
      case (mode_q)
         cps_pkg::MODE_SERIAL:   daisySrc = serialBit_q;                            // R7
         cps_pkg::MODE_PARALLEL: daisySrc = 1'b0;                                   // R9
         default:                daisySrc = (shiftCnt_q != 4'h0) && shift_q[7];
      endcase
   end

   always_comb begin
      fifoInValid      = apTake || syncTake || parTake || serTake;
      fifoInData.mode  = mode_q;
      fifoInData.data  = apTake ? pinSync_q[7:0] : (serTake ? serAcc_d : dataIn);
      fifoOutReady     = (xReqTgl_q == xAckSync_q);
      xData_d          = xData_q;
      xReqTgl_d        = xReqTgl_q;
      if (fifoOutValid && fifoOutReady) begin
         xData_d   = fifoOutData;
         xReqTgl_d = !xReqTgl_q;
      end
   end

   // Readback
   always_comb begin
      rbActive_d = rbActive_q;
      rbHigh_d   = readbackRequest_n ? ((rbHigh_q == cps_pkg::ABORT_HIGHS) ? rbHigh_q : rbHigh_q + 2'h1) : 2'h0;
      rbShift_d  = rbShift_q;
      rbCnt_d    = rbCnt_q;
      rbFresh_d  = rbFresh_q || (rbAckSync_q != rbAckPrev_q);
      rbReqTgl_d = rbReqTgl_q;
      if (!rbActive_q) begin
         if (!readbackRequest_n) begin
            rbActive_d = 1'b1;
            rbCnt_d    = 4'h0;
            // A request still in flight after an abort is reused, else a double toggle hangs
            if (rbReqTgl_q == rbAckSync_q) begin
               rbFresh_d  = 1'b0;
               rbReqTgl_d = !rbReqTgl_q;
            end
         end
      end else if (readbackRequest_n && (rbHigh_d == cps_pkg::ABORT_HIGHS)) begin
         rbActive_d = 1'b0;                                                        // R10
         rbCnt_d    = 4'h0;
      end else if (rbCnt_q <= 4'h1 && rbFresh_d) begin
         rbShift_d  = rbHold_q;
         rbCnt_d    = cps_pkg::SHIFT_CLOCKS;
         rbFresh_d  = 1'b0;
         rbReqTgl_d = !rbReqTgl_q;
      end else if (rbCnt_q != 4'h0) begin
         rbShift_d = {rbShift_q[6:0], 1'b0};                                       // R11
         rbCnt_d   = rbCnt_q - 4'h1;
      end
      readbackData_d = rbActive_d && (rbCnt_d != 4'h0) && rbShift_d[7];
   end

   always_ff @(posedge configClock) begin
      if (linkRst) begin
         apState_q     <= cps_pkg::AP_IDLE;
         apWritePrev_q <= 1'b0;
         shift_q       <= cps_pkg::BYTE_RESET;
         shiftCnt_q    <= 4'h0;
         syncPipe_q    <= cps_pkg::BYTE_RESET;
         syncPipeV_q   <= 1'b0;
         serialBit_q   <= 1'b0;
         serAcc_q      <= cps_pkg::BYTE_RESET;
         serCnt_q      <= 3'h0;
         readyOut      <= 1'b1;
         dataOut       <= 8'h00;
         dataOe        <= 8'h00;
         xData_q       <= '0;
         xReqTgl_q     <= 1'b0;
         rbActive_q    <= 1'b0;
         rbHigh_q      <= 2'h0;
         rbShift_q     <= cps_pkg::BYTE_RESET;
         rbCnt_q       <= 4'h0;
         rbFresh_q     <= 1'b0;
         rbReqTgl_q    <= 1'b0;
         readbackData  <= 1'b0;
      end else begin
         apState_q     <= apState_d;
         apWritePrev_q <= apWritePrev_d;
         shift_q       <= shift_d;
         shiftCnt_q    <= shiftCnt_d;
         syncPipe_q    <= syncPipe_d;
         syncPipeV_q   <= syncPipeV_d;
         serialBit_q   <= serialBit_d;
         serAcc_q      <= serAcc_d;
         serCnt_q      <= serCnt_d;
         readyOut      <= readyOut_d;
         dataOut       <= dataOut_d;
         dataOe        <= dataOe_d;
         xData_q       <= xData_d;
         xReqTgl_q     <= xReqTgl_d;
         rbActive_q    <= rbActive_d;
         rbHigh_q      <= rbHigh_d;
         rbShift_q     <= rbShift_d;
         rbCnt_q       <= rbCnt_d;
         rbFresh_q     <= rbFresh_d;
         rbReqTgl_q    <= rbReqTgl_d;
         readbackData  <= readbackData_d;
      end
   end

   // Falling edge launch leaves half a period of hold downstream
   always_ff @(negedge configClock) begin
      if (linkRst) begin
         daisyOut <= 1'b0;
      end else begin
         daisyOut <= daisySrc;                                                     // R5
      end
   end

   cps_fifo #(
      .WIDTH ($bits(cps_pkg::cps_byte_t)),
      .DEPTH (cps_pkg::FIFO_DEPTH)
   ) uFifo (
      .clk      (configClock),
      .rst      (linkRst),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (fifoInData),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData)
   );

   // ---------------- Core domain ----------------
   logic               xReqMeta_q, xReqSync_q, rbReqMeta_q, rbReqSync_q;
   cps_pkg::cps_byte_t cfgWord_d;
   logic               cfgValid_d, xAckTgl_d, rbAckTgl_d, rbTake_d;
   logic [7:0]         rbHold_d;

   always_comb begin
      cfgWord_d  = cfgWord;
      cfgValid_d = cfgValid && !cfgReady;
      xAckTgl_d  = xAckTgl_q;
      // xData_q is held stable until the acknowledge returns
      if ((xReqSync_q != xAckTgl_q) && (!cfgValid || cfgReady)) begin
         cfgWord_d  = xData_q;
         cfgValid_d = 1'b1;
         xAckTgl_d  = xReqSync_q;
      end
      rbHold_d   = rbHold_q;
      rbAckTgl_d = rbAckTgl_q;
      rbTake_d   = 1'b0;
      if (rbReqSync_q != rbAckTgl_q) begin
         rbHold_d   = rbByte;
         rbAckTgl_d = rbReqSync_q;
         rbTake_d   = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      xReqMeta_q  <= xReqTgl_q;
      xReqSync_q  <= xReqMeta_q;
      rbReqMeta_q <= rbReqTgl_q;
      rbReqSync_q <= rbReqMeta_q;
      if (reset) begin
         cfgWord    <= '0;
         cfgValid   <= 1'b0;
         xAckTgl_q  <= 1'b0;
         rbHold_q   <= cps_pkg::BYTE_RESET;
         rbAckTgl_q <= 1'b0;
         rbTake     <= 1'b0;
      end else begin
         cfgWord    <= cfgWord_d;
         cfgValid   <= cfgValid_d;
         xAckTgl_q  <= xAckTgl_d;
         rbHold_q   <= rbHold_d;
         rbAckTgl_q <= rbAckTgl_d;
         rbTake     <= rbTake_d;
      end
   end

   // ---------------- Assertions, link domain ----------------
   default clocking cbLink @(posedge configClock); endclocking
   default disable iff (linkRst);

   a_busy_bounded: assert property ($fell(readyOut) && fifoInReady |-> ##[1:8] (readyOut || !fifoInReady)) // R1
      else $error("Busy held longer than eight clocks");
   a_busy_after_take: assert property (apTake |=> !readyOut [*8]) // R1
      else $error("Busy did not cover the shift-out");
   a_status_top_only: assert property (dataOe[6:0] == 7'h00 && (!dataOe[7] || dataOut[7] == readyOut)) // R2
      else $error("Status read drove low bits or wrong ready");
   a_async_capture: assert property (apTake |-> fifoInValid && fifoInData.data == pinSync_q[7:0]) // R4
      else $error("Async byte not captured");
   a_async_msb_first: assert property (apTake |=> daisyOut == $past(pinSync_q[7])) // R5
      else $error("Async shift-out does not start with MSB");
   a_sync_delay: assert property (syncTake && !apTake |-> ##2 daisyOut == $past(dataIn[7], 2)) // R6
      else $error("Sync mode first bit not at 1.5 clocks");
   a_serial_forward: assert property ((mode_q == cps_pkg::MODE_SERIAL) && $past(mode_q == cps_pkg::MODE_SERIAL)
                                      |-> daisyOut == $past(serialIn)) // R7
      else $error("Serial bit not forwarded");
   a_par_capture: assert property (parTake |-> fifoInValid && fifoInData.data == dataIn) // R8
      else $error("Parallel byte not taken");
   a_par_silent: assert property ((mode_q == cps_pkg::MODE_PARALLEL) && $past(mode_q == cps_pkg::MODE_PARALLEL)
                                  |-> !daisyOut) // R9
      else $error("Parallel mode forwarded data");
   a_rb_abort: assert property (rbActive_q && readbackRequest_n ##1 readbackRequest_n |=> !rbActive_q) // R10
      else $error("Readback not aborted");
   a_rb_idle_low: assert property (!rbActive_q |=> !readbackData) // R11
      else $error("Readback data outside readback");

   c_async_write: cover property (apTake ##1 !readyOut [*8] ##1 readyOut);
   c_sync_byte: cover property (syncTake ##2 daisyOut);
   c_rb_abort: cover property (rbActive_q ##1 rbActive_q && readbackRequest_n ##1 !rbActive_q);
   c_fifo_full: cover property (!fifoInReady);

endmodule // cps_config_port

// ===== hw/cps_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cps_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign inReady  = (cnt_q != FULL);
   assign outValid = (cnt_q != '0);
   assign outData  = mem_q[rd_q];

   always_comb begin
      push  = inValid && inReady;
      pop   = outValid && outReady;
      wr_d  = push ? ((wr_q == LAST) ? '0 : wr_q + 1'b1) : wr_q;
      rd_d  = pop ? ((rd_q == LAST) ? '0 : rd_q + 1'b1) : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
      if (push) begin
         mem_q[wr_q] <= inData;
      end
   end

endmodule // cps_fifo

// ===== hw/cps_pkg.sv
// Shared types and constants of the configuration load and readback port.
// Assumes a core clock domain and a host-driven configuration clock domain.
package cps_pkg;

   // Load modes, chosen by the mode straps
   typedef enum logic [1:0] {
      MODE_ASYNC    = 2'h0,
      MODE_SYNC     = 2'h1,
      MODE_PARALLEL = 2'h2,
      MODE_SERIAL   = 2'h3
   } cps_mode_t;

   // Asynchronous write handling
   typedef enum logic [1:0] {
      AP_IDLE  = 2'h0,
      AP_SHIFT = 2'h1,
      AP_WAIT  = 2'h3
   } cps_ap_state_t;

   // One configuration byte with the mode it arrived in
   typedef struct packed {
      logic [7:0] data;
      cps_mode_t  mode;
   } cps_byte_t;

   localparam int         BYTE_BITS    = 8;
   localparam logic [3:0] SHIFT_CLOCKS = 4'h8;
   localparam logic [1:0] ABORT_HIGHS  = 2'h2;
   localparam int         FIFO_DEPTH   = 8;
   localparam logic [7:0] BYTE_RESET   = 8'h00;
   localparam logic [1:0] SYNC_RESET   = 2'h3;

endpackage

// ===== tb/cps_config_port_tb.sv
// Self-checking bench of the configuration port: host model on the pins, random core consumer.
// Assumes the design asserts its own rules internally; this bench checks port behaviour.
`timescale 1ns/1ps
module cps_config_port_tb;
   logic               mclk = 1'b0;
   logic               reset;
   logic               configClock;
   cps_pkg::cps_mode_t mode;
   logic               chipSelectA_n;
   logic               chipSelectB;
   logic               writeStrobe_n;
   logic               readStrobe_n;
   logic [7:0]         dataIn;
   logic [7:0]         dataOut;
   logic [7:0]         dataOe;
   logic               readyOut;
   logic               serialIn;
   logic               daisyOut;
   logic               readbackRequest_n;
   logic               readbackData;
   cps_pkg::cps_byte_t cfgWord;
   logic               cfgValid;
   logic               cfgReady;
   logic [7:0]         rbByte;
   logic               rbTake;
   logic               holdCore;
   logic [16:0]        bits;
   logic [7:0]         pd;
   int                 n;
   int                 errorCnt = 0;
   int                 checkCount = 0;
   int                 rbTakes = 0;
   int                 seed = 32'hfd2d9d24;
   cps_pkg::cps_byte_t expQ[$];

   always #5 mclk = ~mclk;

   cps_host_model cps_host_model_i (.configClock(configClock), .chipSelectA_n(chipSelectA_n),
      .chipSelectB(chipSelectB), .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n),
      .dataIn(dataIn), .serialIn(serialIn), .readbackRequest_n(readbackRequest_n));

   cps_config_port cps_config_port_i (.mclk(mclk), .reset(reset), .configClock(configClock), .mode(mode),
      .chipSelectA_n(chipSelectA_n), .chipSelectB(chipSelectB), .writeStrobe_n(writeStrobe_n),
      .readStrobe_n(readStrobe_n), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
      .readyOut(readyOut), .serialIn(serialIn), .daisyOut(daisyOut), .readbackRequest_n(readbackRequest_n),
      .readbackData(readbackData), .cfgWord(cfgWord), .cfgValid(cfgValid), .cfgReady(cfgReady),
      .rbByte(rbByte), .rbTake(rbTake));

   task automatic stopTest();
      $display("Checks %0d, mismatches %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic giveUp(input string what);
      errorCnt++;
      $display("[ERR] %s expected done seen timeout", what);
      stopTest();
   endtask

   task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
      checkCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rise(input int k);
      repeat (k) @(posedge configClock);
      #1;
   endtask

   task automatic setMode(input cps_pkg::cps_mode_t m);
      @(posedge mclk);
      mode <= m;
      rise(6);
   endtask

   task automatic drain(input string what);
      int k;
      k = 0;
      while (expQ.size() != 0 && k < 500) begin
         @(posedge mclk);
         k++;
      end
      if (k == 500) giveUp(what);
      $display("%s test done", what);
   endtask

   task automatic asyncWrite(input logic [7:0] d, input logic withRead);
      int k;
      k = 0;
      expQ.push_back({d, cps_pkg::MODE_ASYNC});
      cps_host_model_i.drive(1'b1, 1'b1, 1'b0, d);
      while (readyOut !== 1'b0 && k < 20) begin
         rise(1);
         k++;
      end
      if (k == 20) giveUp("async take");
      // Strobe held until busy is seen, then dropped
      cps_host_model_i.drive(withRead, 1'b0, withRead, d);
      for (int i = 7; i >= 0; i--) begin
         @(negedge configClock);
         #1;
         check("daisy bit", 10'(d[i]), 10'(daisyOut));
         check("busy", 10'h000, 10'(readyOut));
         if (withRead && i == 2) check("status enable", 10'h080, 10'(dataOe));
         if (withRead && i == 2) check("status busy", 10'h000, 10'(dataOut));
      end
      rise(1);
      check("ready again", 10'h001, 10'(readyOut));
      if (withRead) begin
         rise(3);
         check("status ready", 10'h080, 10'(dataOut));
         cps_host_model_i.drive(1'b0, 1'b0, 1'b0, d);
         rise(4);
         check("status released", 10'h000, 10'(dataOe));
      end
   endtask

   task automatic syncWrite(input logic [7:0] d);
      expQ.push_back({d, cps_pkg::MODE_SYNC});
      cps_host_model_i.drive(1'b1, 1'b1, 1'b0, d);
      rise(1);
      cps_host_model_i.drive(1'b0, 1'b0, 1'b0, d);
      @(negedge configClock);
      for (int i = 7; i >= 0; i--) begin
         @(negedge configClock);
         #1;
         check("sync daisy bit", 10'(d[i]), 10'(daisyOut));
      end
      rise(2);
   endtask

   // Random consumer stalls; serial-mode bytes carry no framing and are not scored
   always @(posedge mclk) cfgReady <= holdCore ? 1'b0 : ($random(seed) % 3 != 0);

   always @(posedge mclk) begin
      if (!reset && cfgValid === 1'b1 && cfgReady && cfgWord.mode !== cps_pkg::MODE_SERIAL) begin
         if (expQ.size() == 0) begin
            errorCnt++;
            $display("[ERR] config word expected none seen %h", cfgWord);
         end else
            check("config word", expQ.pop_front(), cfgWord);
      end
   end

   always @(posedge mclk) if (rbTake === 1'b1) rbTakes++;

   initial begin
      #800000;
      giveUp("run");
   end

   initial begin
      reset = 1'b1;
      mode = cps_pkg::MODE_ASYNC;
      cfgReady = 1'b0;
      rbByte = 8'h00;
      holdCore = 1'b0;
      // Four core cycles also cover six link edges
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      rise(250);
      for (int k = 0; k < 5; k++)
         asyncWrite(k == 0 ? 8'hff : (k == 1 ? 8'h01 : 8'($random(seed))), k == 1);
      drain("async");
      setMode(cps_pkg::MODE_SYNC);
      for (int k = 0; k < 4; k++)
         syncWrite(k == 0 ? 8'h80 : 8'($random(seed)));
      drain("sync");
      setMode(cps_pkg::MODE_SERIAL);
      bits = 17'($random(seed));
      for (int i = 0; i < 17; i++) begin
         cps_host_model_i.serBit(bits[i]);
         @(negedge configClock);
         #1;
         if (i > 0) check("forwarded bit", 10'(bits[i - 1]), 10'(daisyOut));
         rise(1);
      end
      $display("serial test done");
      setMode(cps_pkg::MODE_PARALLEL);
      rise(60); // Serial leftovers must reach the core before it stalls
      holdCore <= 1'b1;
      cps_host_model_i.drive(1'b0, 1'b1, 1'b0, 8'h5a); // Strobe without select is ignored
      rise(1);
      // Core word and crossing stage hold two, so ten bytes fill the buffer
      for (int k = 0; k < 10; k++) begin
         if (k == 8) begin
            cps_host_model_i.drive(1'b0, 1'b0, 1'b0, 8'h00);
            rise(20);
         end
         pd = k == 7 ? 8'h00 : 8'($random(seed));
         expQ.push_back({pd, cps_pkg::MODE_PARALLEL});
         cps_host_model_i.drive(1'b1, 1'b1, 1'b0, pd);
         @(negedge configClock);
         #1;
         check("parallel daisy", 10'h000, 10'(daisyOut));
         rise(1);
      end
      cps_host_model_i.drive(1'b0, 1'b0, 1'b0, 8'h00);
      rise(20);
      check("full refusal", 10'h000, 10'(readyOut));
      holdCore <= 1'b0;
      drain("parallel");
      @(posedge mclk);
      rbByte <= 8'($random(seed)) | 8'h80;
      rise(2);
      cps_host_model_i.readbackReq(1'b0);
      n = 0;
      while (readbackData !== 1'b1 && n < 100) begin
         rise(1);
         n++;
      end
      if (n == 100) giveUp("readback start");
      for (int i = 6; i >= 0; i--) begin
         rise(1);
         check("readback bit", 10'(rbByte[i]), 10'(readbackData));
      end
      cps_host_model_i.readbackReq(1'b1);
      rise(3);
      for (int i = 0; i < 12; i++) begin
         check("after abort", 10'h000, 10'(readbackData));
         rise(1);
      end
      check("readback takes", 10'h001, 10'(rbTakes >= 2));
      $display("readback test done");
      stopTest();
   end
endmodule // cps_config_port_tb

// ===== tb/cps_host_model.sv
// Host model: makes the configuration clock and drives the load, status and readback pins.
// Assumes the bench calls its tasks just after a rising configClock edge and watches the device.
`timescale 1ns/1ps
module cps_host_model (
   output logic       configClock,
   output logic       chipSelectA_n,
   output logic       chipSelectB,
   output logic       writeStrobe_n,
   output logic       readStrobe_n,
   output logic [7:0] dataIn,
   output logic       serialIn,
   output logic       readbackRequest_n
);
   logic       clkRun;
   logic [7:0] lastByte;

   initial begin
      configClock = 1'b0;
      clkRun = 1'b1;
      lastByte = 8'h00;
      chipSelectA_n = 1'b1;
      chipSelectB = 1'b0;
      writeStrobe_n = 1'b1;
      readStrobe_n = 1'b1;
      dataIn = 8'hff;
      serialIn = 1'b0;
      readbackRequest_n = 1'b1;
   end

   // Stands still when stopped, as a host clock does between loads
   always #3 if (clkRun) configClock = ~configClock;

   // Values hold until the next call
   task automatic drive(input logic sel, input logic wr, input logic rd, input logic [7:0] d);
      chipSelectA_n <= ~sel;
      chipSelectB <= sel;
      writeStrobe_n <= ~wr;
      readStrobe_n <= ~rd;
      dataIn <= wr ? d : ~lastByte; // Released bus never repeats the last byte
      if (wr) lastByte <= d;
   endtask

   task automatic serBit(input logic b);
      serialIn <= b;
   endtask

   task automatic readbackReq(input logic level_n);
      readbackRequest_n <= level_n;
   endtask
endmodule // cps_host_model
